//--- src/uep_cmd_rx.sv
`timescale 1ns/1ps
module uep_cmd_rx (
  // clock and reset
  input  wire logic              mclk,
  input  wire logic              rst_b,
  // command byte from master
  input  wire logic              cmd_wr,
  input  wire logic [7:0]        cmd_byte,
  output logic                   ready,
  // decoded command
  output uep_pkg::uep_cmd_t      cmd
);

  typedef struct packed {
    logic [1:0]        low_cnt;
    logic              have_wr;
    logic              phase;
    logic [3:0]        hi_nib;
    logic [5:0]        addr;
    uep_pkg::uep_cmd_t cmd;
  } uep_rx_t;

  uep_rx_t s;
  uep_rx_t next_s;
  logic    accept;

  // ****************************************************************
  // byte decode and ready pacing
  // ****************************************************************
  assign ready  = (s.low_cnt == 2'h0);
  assign accept = cmd_wr && ready;
  assign cmd    = s.cmd;

  // next state of the decoder
  always_comb begin
    next_s             = s;
    next_s.cmd.addr_wr = 1'b0;
    next_s.cmd.dat_wr  = 1'b0;
    if (s.low_cnt != 2'h0) begin
      next_s.low_cnt = s.low_cnt - 2'h1;
    end
    if (accept) begin
      next_s.low_cnt = uep_pkg::READY_LOW_CYC;
      if (cmd_byte[uep_pkg::CB_ADDR_BIT]) begin
        // new address drops any half-sent data
        next_s.addr        = cmd_byte[5:0];
        next_s.have_wr     = !cmd_byte[uep_pkg::CB_READ_BIT];
        next_s.phase       = 1'b0;
        next_s.cmd.addr_wr = 1'b1;
        next_s.cmd.rd      = cmd_byte[uep_pkg::CB_READ_BIT];
        next_s.cmd.addr    = cmd_byte[5:0];
      end else if (s.have_wr) begin
        if (!s.phase) begin
          next_s.hi_nib = cmd_byte[3:0];
          next_s.phase  = 1'b1;
        end else begin
          next_s.phase      = 1'b0;
          next_s.cmd.dat_wr = 1'b1;
          next_s.cmd.rd     = 1'b0;
          next_s.cmd.addr   = s.addr;
          next_s.cmd.dat    = {s.hi_nib, cmd_byte[3:0]};
        end
      end
    end
  end

  // state register
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  chk_ready_drop: assert property (@(posedge mclk) disable iff (!rst_b)
    accept |=> !ready [*2] ##1 ready)
    else $error("ready not low for two cycles after a command byte");

  chk_nibble_pair: assert property (@(posedge mclk) disable iff (!rst_b)
    s.cmd.dat_wr |-> s.cmd.dat[3:0] == $past(cmd_byte[3:0]))
    else $error("data byte not built from upper then lower nibble");

endmodule

//--- src/uep_ep0.sv
`timescale 1ns/1ps
// Behaviour
// - standard requests other than endpoint features are answered by the device without master help.
// - unserviced setup packet raises the setup event.
// - each of the first eight setup register reads returns the next setup byte; later reads return zero.
// - non-zero write to setup register stalls the current request.
// - data phase raises buffer event: IN when buffer free, OUT when packet lands.
// - requested length from setup bytes six and seven caps all IN data.
// - short or zero-length IN packet finishes with automatic status handshake.
// - only byte count writes commit endpoint zero packets.
// - OUT bytes reaching requested length complete the status handshake.
// - new setup before completion raises another setup event.
// - non-standard no-data request is acknowledged by the device immediately.
// - endpoint set and clear feature requests are forwarded with setup event.
// - toggle bit 7 reads toggle; bit 6 forces DATA1, bit 5 DATA0.
// - bit 4 direction, bits 3..0 endpoint 0,1,2,6,8 select toggle.
// - extended registers reached through address low, high and data ports.
// - bit 7 marks address byte, bit 6 read; data bytes carry nibbles.
// - ready drops for two cycles after each command byte, then rises again.
// - read request reserves interrupt pin; other events wait until read ends.
module uep_ep0 (
  // clock and reset
  input  wire logic              mclk,
  input  wire logic              rst_b,
  // command port from master
  input  wire logic              cmd_wr,
  input  wire logic [7:0]        cmd_byte,
  output logic                   ready,
  output logic [7:0]             rd_data,
  output logic                   int_b,
  // event flags
  output logic [1:0]             event_status,
  input  wire logic [1:0]        event_clear,
  // usb engine: setup and handshake
  input  wire logic              usb_setup_valid,
  input  wire logic [63:0]       usb_setup_pkt,
  output logic                   status_ack,
  output logic                   ep0_stall,
  // usb engine: endpoint zero data
  output logic                   usb_in_armed,
  output logic [6:0]             usb_in_count,
  input  wire logic              usb_in_taken,
  output logic                   usb_out_open,
  input  wire logic              usb_out_wr,
  input  wire logic [7:0]        usb_out_data,
  input  wire logic              usb_out_end,
  input  wire logic [5:0]        usb_buf_addr,
  output logic [7:0]             usb_buf_rdata,
  // toggles and identifiers
  output logic [15:0]            tog_in,
  output logic [15:0]            tog_out,
  output logic [47:0]            dev_ids,
  output logic                   ids_loaded
);

  typedef struct packed {
    uep_pkg::uep_state_t st;
    logic [63:0][7:0]    buffer;
    logic [7:0][7:0]     setup;
    logic [3:0]          sptr;
    logic                stall;
    logic [6:0]          wptr;
    logic [6:0]          rptr;
    logic [6:0]          optr;
    logic [6:0]          out_count;
    logic [6:0]          in_count;
    logic                in_armed;
    logic [15:0]         remain;
    logic [15:0]         got;
    logic [1:0]          evt;
    logic                ack;
    logic [7:0]          rd_data;
    logic                rd_active;
    logic                rd_done;
    logic [15:0]         ext_addr;
    logic [6:0]          data_toggle_control;
    logic [15:0]         tog_in;
    logic [15:0]         tog_out;
    logic [8:0]          descriptor_load_port_idx;
    logic [15:0]         descriptor_load_port_len;
    logic [5:0][7:0]     ids;
    logic                ids_loaded;
    logic [7:0]          usb_rdata;
  } uep_ep0_t;

  uep_ep0_t          s;
  uep_ep0_t          next_s;
  uep_pkg::uep_cmd_t cmd;

  // index just past the six id bytes of the default descriptor
  localparam logic [8:0] DESCRIPTOR_LOAD_PORT_END = uep_pkg::DESCRIPTOR_LOAD_PORT_HDR_LEN + 9'h006;

  // ****************************************************************
  // command byte decoder
  // ****************************************************************
  uep_cmd_rx u_rx (
    .mclk     (mclk),
    .rst_b    (rst_b),
    .cmd_wr   (cmd_wr),
    .cmd_byte (cmd_byte),
    .ready    (ready),
    .cmd      (cmd)
  );

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign rd_data       = s.rd_data;
  assign int_b         = !(s.rd_active ? s.rd_done : (s.evt != 2'h0));
  assign event_status  = s.evt;
  assign status_ack    = s.ack;
  assign ep0_stall     = s.stall;
  assign usb_in_armed  = s.in_armed;
  assign usb_in_count  = s.in_count;
  assign usb_out_open  = (s.st == uep_pkg::ST_OUT_WAIT);
  assign usb_buf_rdata = s.usb_rdata;
  assign tog_in        = s.tog_in;
  assign tog_out       = s.tog_out;
  assign dev_ids       = s.ids;
  assign ids_loaded    = s.ids_loaded;

  // setup fields of the arriving packet
  logic [7:0]  new_type;
  logic [7:0]  new_req;
  logic [15:0] new_wlen;
  logic        new_fwd;
  assign new_type = usb_setup_pkt[7:0];
  assign new_req  = usb_setup_pkt[15:8];
  assign new_wlen = usb_setup_pkt[63:48];
  // non-standard or endpoint feature requests go to the master
  assign new_fwd  = (new_type[6:5] != 2'h0) ||
                    ((new_type[4:0] == uep_pkg::RECIP_ENDPOINT) &&
                     ((new_req == uep_pkg::REQ_SET_FEAT) ||
                      (new_req == uep_pkg::REQ_CLEAR_FEAT)));

  // ****************************************************************
  // control transfer engine
  // ****************************************************************
  always_comb begin
    logic [1:0]  set_evt;
    logic [6:0]  len;
    logic [15:0] left;
    logic [15:0] rcvd;
    logic [3:0]  tep;
    set_evt   = 2'h0;
    len       = 7'h00;
    left      = 16'h0000;
    rcvd      = 16'h0000;
    tep       = s.data_toggle_control[3:0];
    next_s    = s;
    next_s.ack       = 1'b0;
    next_s.usb_rdata = s.buffer[usb_buf_addr];
    // a new address byte or a completed data byte ends a reserved read
    if (cmd.addr_wr || cmd.dat_wr) begin
      next_s.rd_active = 1'b0;
      next_s.rd_done   = 1'b0;
    end
    // read requests put one byte on the data bus
    if (cmd.addr_wr && cmd.rd) begin
      next_s.rd_active = 1'b1;
      next_s.rd_done   = 1'b1;
      next_s.rd_data   = 8'h00;
      case (cmd.addr)
        uep_pkg::CMD_EP0_BUF: begin
          next_s.rd_data = s.buffer[s.rptr[5:0]];
          next_s.rptr    = s.rptr + 7'h01;
          if ((s.st == uep_pkg::ST_OUT_HELD) && (s.rptr + 7'h01 >= s.out_count)) begin
            if (s.got >= s.remain) begin
              next_s.ack = 1'b1;
              next_s.st  = uep_pkg::ST_IDLE;
            end else begin
              next_s.st   = uep_pkg::ST_OUT_WAIT;
              next_s.optr = 7'h00;
            end
          end
        end
        uep_pkg::CMD_SETUP: begin
          if (s.sptr < uep_pkg::SETUP_LEN) begin
            next_s.rd_data = s.setup[s.sptr[2:0]];
            next_s.sptr    = s.sptr + 4'h1;
          end
        end
        uep_pkg::CMD_EP0_BC: begin
          next_s.rd_data = {1'b0, s.out_count};
        end
        uep_pkg::CMD_EXT_DATA: begin
          if (s.ext_addr == uep_pkg::EXT_TOG_ADDR) begin
            next_s.rd_data = {s.data_toggle_control[uep_pkg::TOG_IO_BIT] ? s.tog_in[tep]
                                                            : s.tog_out[tep], s.data_toggle_control};
          end
        end
        default: begin
          next_s.rd_data = 8'h00;
        end
      endcase
    end
    // descriptor load restarts with its write address
    if (cmd.addr_wr && !cmd.rd && (cmd.addr == uep_pkg::CMD_DESCRIPTOR_LOAD_PORT)) begin
      next_s.descriptor_load_port_idx = 9'h000;
    end
    // data bytes of write requests
    if (cmd.dat_wr) begin
      case (cmd.addr)
        uep_pkg::CMD_DESCRIPTOR_LOAD_PORT: begin
          next_s.descriptor_load_port_idx = s.descriptor_load_port_idx + 9'h001;
          if (s.descriptor_load_port_idx == 9'h000) begin
            next_s.descriptor_load_port_len[7:0] = cmd.dat;
          end else if (s.descriptor_load_port_idx == 9'h001) begin
            next_s.descriptor_load_port_len[15:8] = cmd.dat;
            next_s.ids_loaded     = 1'b0;
          end else if ((s.descriptor_load_port_len == uep_pkg::DEFAULT_DESCRIPTOR_LOAD_PORT_LEN) &&
                       (s.descriptor_load_port_idx < DESCRIPTOR_LOAD_PORT_END)) begin
            next_s.ids[s.descriptor_load_port_idx[2:0] - 3'h2] = cmd.dat;
            next_s.ids_loaded = (s.descriptor_load_port_idx == DESCRIPTOR_LOAD_PORT_END - 9'h001);
          end
        end
        uep_pkg::CMD_EP0_BUF: begin
          if ((s.st == uep_pkg::ST_IN_FILL) && (s.wptr < uep_pkg::EP0_MAX)) begin
            next_s.buffer[s.wptr[5:0]] = cmd.dat;
            next_s.wptr = s.wptr + 7'h01;
          end
        end
        uep_pkg::CMD_SETUP: begin
          if (cmd.dat != 8'h00) begin
            next_s.stall    = 1'b1;
            next_s.st       = uep_pkg::ST_IDLE;
            next_s.in_armed = 1'b0;
          end
        end
        uep_pkg::CMD_EP0_BC: begin
          if (s.st == uep_pkg::ST_IN_FILL) begin
            // only this write commits an endpoint zero packet
            len = uep_pkg::uep_clip_count(cmd.dat);
            if ({9'h000, len} > s.remain) begin
              len = s.remain[6:0];
            end
            next_s.in_count = len;
            next_s.in_armed = 1'b1;
            next_s.st       = uep_pkg::ST_IN_SENT;
          end else if ((s.st == uep_pkg::ST_IDLE) && (cmd.dat == 8'h00)) begin
            next_s.ack = 1'b1;
          end
        end
        uep_pkg::CMD_EXT_LO: begin
          next_s.ext_addr[7:0] = cmd.dat;
        end
        uep_pkg::CMD_EXT_HI: begin
          next_s.ext_addr[15:8] = cmd.dat;
        end
        uep_pkg::CMD_EXT_DATA: begin
          if (s.ext_addr == uep_pkg::EXT_TOG_ADDR) begin
            next_s.data_toggle_control = cmd.dat[6:0];
            tep = s.data_toggle_control[3:0];
            // force bits act on the selection already held
            if (uep_pkg::uep_ep_valid(tep) && (cmd.dat[4:0] == s.data_toggle_control[4:0])) begin
              if (cmd.dat[uep_pkg::TOG_S_BIT]) begin
                if (s.data_toggle_control[uep_pkg::TOG_IO_BIT]) next_s.tog_in[tep] = 1'b1;
                else next_s.tog_out[tep] = 1'b1;
              end
              if (cmd.dat[uep_pkg::TOG_R_BIT]) begin
                if (s.data_toggle_control[uep_pkg::TOG_IO_BIT]) next_s.tog_in[tep] = 1'b0;
                else next_s.tog_out[tep] = 1'b0;
              end
            end
          end
        end
        default: begin
          next_s.ext_addr = s.ext_addr;
        end
      endcase
    end
    // host side of the data phase
    case (s.st)
      uep_pkg::ST_IN_SENT: begin
        if (usb_in_taken) begin
          left            = s.remain - {9'h000, s.in_count};
          next_s.remain   = left;
          next_s.in_armed = 1'b0;
          if ((s.in_count < uep_pkg::EP0_MAX) || (left == 16'h0000)) begin
            next_s.ack = 1'b1;
            next_s.st  = uep_pkg::ST_IDLE;
          end else begin
            next_s.wptr      = 7'h00;
            set_evt[uep_pkg::EVT_BUF] = 1'b1;
            next_s.st        = uep_pkg::ST_IN_FILL;
          end
        end
      end
      uep_pkg::ST_OUT_WAIT: begin
        if (usb_out_wr && (s.optr < uep_pkg::EP0_MAX)) begin
          next_s.buffer[s.optr[5:0]] = usb_out_data;
          next_s.optr = s.optr + 7'h01;
        end
        if (usb_out_end) begin
          rcvd             = s.got + {9'h000, s.optr};
          next_s.got       = rcvd;
          next_s.out_count = s.optr;
          next_s.rptr      = 7'h00;
          if (s.optr == 7'h00) begin
            next_s.ack = 1'b1;
            next_s.st  = uep_pkg::ST_IDLE;
          end else begin
            set_evt[uep_pkg::EVT_BUF] = 1'b1;
            next_s.st = uep_pkg::ST_OUT_HELD;
          end
        end
      end
      uep_pkg::ST_IDLE, uep_pkg::ST_IN_FILL, uep_pkg::ST_OUT_HELD: begin
        next_s.st = next_s.st;
      end
      default: begin
        next_s.st = uep_pkg::ST_IDLE;
      end
    endcase
    // a setup packet overrides any transfer in flight
    if (usb_setup_valid) begin
      next_s.setup    = usb_setup_pkt;
      next_s.sptr     = 4'h0;
      next_s.stall    = 1'b0;
      next_s.in_armed = 1'b0;
      next_s.remain   = new_wlen;
      next_s.got      = 16'h0000;
      next_s.wptr     = 7'h00;
      next_s.optr     = 7'h00;
      next_s.st       = uep_pkg::ST_IDLE;
      if (!new_fwd) begin
        next_s.ack = 1'b1;
      end else begin
        set_evt[uep_pkg::EVT_SETUP] = 1'b1;
        if (new_wlen == 16'h0000) begin
          next_s.ack = 1'b1;
        end else if (new_type[7]) begin
          set_evt[uep_pkg::EVT_BUF] = 1'b1;
          next_s.st = uep_pkg::ST_IN_FILL;
        end else begin
          next_s.st = uep_pkg::ST_OUT_WAIT;
        end
      end
    end
    // sticky events: a new event beats a clear in the same cycle
    next_s.evt = (s.evt & ~event_clear) | set_evt;
  end

  // state register
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      s        <= '0;
      s.st     <= uep_pkg::ST_IDLE;
      s.data_toggle_control <= uep_pkg::DATA_TOGGLE_CONTROL_RST[6:0];
    end else begin
      s <= next_s;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  chk_setup_event: assert property (@(posedge mclk) disable iff (!rst_b)
    usb_setup_valid && new_fwd |=> s.evt[uep_pkg::EVT_SETUP])
    else $error("forwarded setup did not raise the setup event");

  chk_std_auto: assert property (@(posedge mclk) disable iff (!rst_b)
    usb_setup_valid && !new_fwd |=> s.ack && (s.st == uep_pkg::ST_IDLE))
    else $error("standard request not answered by the device");

  chk_nodata_ack: assert property (@(posedge mclk) disable iff (!rst_b)
    usb_setup_valid && new_fwd && (new_wlen == 16'h0000) |=> s.ack)
    else $error("no-data forwarded request not acknowledged");

  chk_stall_write: assert property (@(posedge mclk) disable iff (!rst_b)
    cmd.dat_wr && (cmd.addr == uep_pkg::CMD_SETUP) && (cmd.dat != 8'h00) &&
    !usb_setup_valid |=> s.stall && !s.in_armed)
    else $error("non-zero setup write did not stall");

  chk_sptr_reset: assert property (@(posedge mclk) disable iff (!rst_b)
    usb_setup_valid |=> (s.sptr == 4'h0))
    else $error("setup read pointer not reset");

  chk_in_cap: assert property (@(posedge mclk) disable iff (!rst_b)
    $rose(s.in_armed) |-> (s.in_count <= uep_pkg::EP0_MAX) &&
                          ({9'h000, s.in_count} <= s.remain))
    else $error("armed IN count exceeds a packet or the requested length");

  chk_short_done: assert property (@(posedge mclk) disable iff (!rst_b)
    (s.st == uep_pkg::ST_IN_SENT) && usb_in_taken && !usb_setup_valid &&
    (s.in_count < uep_pkg::EP0_MAX) |=> s.ack ##1 !s.ack)
    else $error("short IN packet did not finish the transfer");

  chk_int_reserved: assert property (@(posedge mclk) disable iff (!rst_b)
    cmd.addr_wr && cmd.rd |=> !int_b [*3])
    else $error("read data not signalled on the interrupt pin");

endmodule

//--- src/uep_pkg.sv
package uep_pkg;

  // ****************************************************************
  // command register addresses
  // ****************************************************************
  localparam logic [5:0] CMD_DESCRIPTOR_LOAD_PORT      = 6'h30;
  localparam logic [5:0] CMD_EP0_BUF   = 6'h31;
  localparam logic [5:0] CMD_SETUP     = 6'h32;
  localparam logic [5:0] CMD_EP0_BC    = 6'h33;
  localparam logic [5:0] CMD_EXT_LO    = 6'h3a;
  localparam logic [5:0] CMD_EXT_HI    = 6'h3b;
  localparam logic [5:0] CMD_EXT_DATA  = 6'h3c;

  // ****************************************************************
  // command byte fields
  // ****************************************************************
  localparam int         CB_ADDR_BIT   = 7;
  localparam int         CB_READ_BIT   = 6;
  localparam logic [1:0] READY_LOW_CYC = 2'h2;

  // ****************************************************************
  // extended toggle-control register
  // ****************************************************************
  localparam logic [15:0] EXT_TOG_ADDR = 16'he683;
  localparam logic [7:0]  DATA_TOGGLE_CONTROL_RST   = 8'h32;
  localparam int          TOG_Q_BIT    = 7;
  localparam int          TOG_S_BIT    = 6;
  localparam int          TOG_R_BIT    = 5;
  localparam int          TOG_IO_BIT   = 4;

  // ****************************************************************
  // endpoint zero and setup packet
  // ****************************************************************
  localparam logic [6:0]  EP0_MAX          = 7'h40;
  localparam logic [3:0]  SETUP_LEN        = 4'h8;
  localparam logic [15:0] DEFAULT_DESCRIPTOR_LOAD_PORT_LEN = 16'h0006;
  localparam logic [8:0]  DESCRIPTOR_LOAD_PORT_HDR_LEN     = 9'h002;
  localparam logic [7:0]  REQ_CLEAR_FEAT   = 8'h01;
  localparam logic [7:0]  REQ_SET_FEAT     = 8'h03;
  localparam logic [4:0]  RECIP_ENDPOINT   = 5'h02;
  localparam int          EVT_SETUP        = 0;
  localparam int          EVT_BUF          = 1;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [4:0] {
    ST_IDLE     = 5'h01,
    ST_IN_FILL  = 5'h02,
    ST_IN_SENT  = 5'h04,
    ST_OUT_WAIT = 5'h08,
    ST_OUT_HELD = 5'h10
  } uep_state_t;

  typedef struct packed {
    logic       addr_wr;
    logic       rd;
    logic       dat_wr;
    logic [5:0] addr;
    logic [7:0] dat;
  } uep_cmd_t;

  // endpoint numbers that own a toggle
  function automatic logic uep_ep_valid(input logic [3:0] ep);
    uep_ep_valid = (ep == 4'h0) || (ep == 4'h1) || (ep == 4'h2) ||
                   (ep == 4'h6) || (ep == 4'h8);
  endfunction

  // byte count above one packet is taken as one full packet
  function automatic logic [6:0] uep_clip_count(input logic [7:0] n);
    uep_clip_count = (n > {1'b0, EP0_MAX}) ? EP0_MAX : n[6:0];
  endfunction

endpackage

//--- testbench/uep_ep0_bench.sv
`timescale 1ns/1ps
module uep_ep0_bench;
  logic        mclk = 0, rst_b = 0, cmd_wr = 0, ready, int_b, status_ack, ep0_stall;
  logic        usb_setup_valid = 0, usb_in_armed, usb_in_taken, usb_out_open, ids_loaded;
  logic [7:0]  cmd_byte = 8'h00, rd_data, usb_buf_rdata, v;
  logic [1:0]  event_status, event_clear = 2'h0;
  logic [63:0] pkt = 64'h0002_0000_0000_55c0;
  logic [6:0]  usb_in_count;
  logic [15:0] tog_in, tog_out;
  logic [47:0] dev_ids;
  logic [5:0]  buf_addr = 6'h00;
  logic        usb_out_wr, usb_out_end;
  logic [7:0]  usb_out_data;
  int          mismatches = 0, checks = 0, n, a0, n_ack = 0;
  uep_ep0 u_uep_ep0 (.mclk(mclk), .rst_b(rst_b), .cmd_wr(cmd_wr), .cmd_byte(cmd_byte),
    .ready(ready), .rd_data(rd_data), .int_b(int_b), .event_status(event_status),
    .event_clear(event_clear), .usb_setup_valid(usb_setup_valid), .usb_setup_pkt(pkt),
    .status_ack(status_ack), .ep0_stall(ep0_stall), .usb_in_armed(usb_in_armed),
    .usb_in_count(usb_in_count), .usb_in_taken(usb_in_taken), .usb_out_open(usb_out_open),
    .usb_out_wr(usb_out_wr), .usb_out_data(usb_out_data), .usb_out_end(usb_out_end),
    .usb_buf_addr(buf_addr),
    .usb_buf_rdata(usb_buf_rdata), .tog_in(tog_in), .tog_out(tog_out), .dev_ids(dev_ids),
    .ids_loaded(ids_loaded));
  uep_usb_partner u_uep_usb_partner (.mclk(mclk), .usb_in_armed(usb_in_armed),
    .usb_in_taken(usb_in_taken), .usb_out_open(usb_out_open), .usb_out_wr(usb_out_wr),
    .usb_out_data(usb_out_data), .usb_out_end(usb_out_end));
  // clock and handshake capture
  initial forever #20 mclk = ~mclk;
  always @(posedge mclk) if (status_ack === 1'b1) n_ack <= n_ack + 1;
  task chk(input string name, input logic [63:0] exp, input logic [63:0] got);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask
  // one command byte, held until ready has accepted it
  task send(input logic [7:0] b);
    n = 0;
    while (ready !== 1'b1 && n < 50) begin
      @(posedge mclk); #1; n++;
    end
    if (ready !== 1'b1) mismatches++;
    cmd_wr = 1; cmd_byte = b;
    @(posedge mclk); #1;
    cmd_wr = 0;
  endtask
  task nib(input logic [7:0] d);
    send({4'h0, d[7:4]}); send({4'h0, d[3:0]});
  endtask
  task wr(input logic [5:0] a, input logic [7:0] d);
    send({2'b10, a}); nib(d);
  endtask
  task rd(input logic [5:0] a, output logic [7:0] d);
    send({2'b11, a});
    repeat (2) @(posedge mclk);
    #1 d = rd_data;
  endtask
  // one setup packet from the host, valid for one clock
  task host_setup(input logic [63:0] p);
    pkt = p;
    @(posedge mclk); #1 usb_setup_valid = 1;
    @(posedge mclk); #1 usb_setup_valid = 0;
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    #100000 mismatches++;
    wrap_up;
  end
  initial begin
    repeat (2) @(posedge mclk); #1 rst_b = 1;
    chk("ready", 1, ready); chk("int_b", 1, int_b); chk("events", 0, event_status);
    // default descriptor: length 6 then ids low byte first
    send({2'b10, uep_pkg::CMD_DESCRIPTOR_LOAD_PORT}); chk("ready_low", 0, ready);
    nib(8'h06); nib(8'h00); nib(8'h34); nib(8'h12); nib(8'h78); nib(8'h56); nib(8'hbc);
    nib(8'h9a); repeat (3) @(posedge mclk);
    #1 chk("dev_ids", 48'h9abc_5678_1234, dev_ids); chk("ids_loaded", 1, ids_loaded);
    $display("test descriptor done");
    // standard request: answered by the device, no event
    a0 = n_ack; host_setup(64'h0012_0000_0100_0680);
    repeat (2) @(posedge mclk); #1 chk("std_ack", a0 + 1, n_ack);
    chk("std_events", 0, event_status);
    // forwarded IN request with wLength 2
    host_setup(64'h0002_0000_0000_55c0);
    @(posedge mclk); #1 chk("events", 2'h3, event_status);
    chk("int_evt", 0, int_b);
    for (int i = 0; i < 8; i++) begin
      rd(uep_pkg::CMD_SETUP, v); chk("setup_byte", pkt[8*i+:8], v);
    end
    chk("int_read", 0, int_b);
    event_clear = 2'h3; @(posedge mclk); #1 event_clear = 2'h0;
    wr(uep_pkg::CMD_EP0_BUF, 8'ha5); wr(uep_pkg::CMD_EP0_BUF, 8'h5a);
    a0 = n_ack; wr(uep_pkg::CMD_EP0_BC, 8'h04);
    n = 0; while (usb_in_armed !== 1'b1 && n < 20) begin @(posedge mclk); #1 n++; end
    chk("in_count", 2, usb_in_count);
    repeat (12) @(posedge mclk); #1 chk("status_ack", a0 + 1, n_ack);
    wr(uep_pkg::CMD_SETUP, 8'h01); repeat (2) @(posedge mclk);
    #1 chk("stall", 1, ep0_stall);
    // long IN reply: over-size count sends one full packet, zero-length packet ends it
    a0 = n_ack; host_setup(64'h0080_0000_0000_55c0);
    for (int i = 0; i < 64; i++) wr(uep_pkg::CMD_EP0_BUF, 8'(i));
    buf_addr = 6'h05; event_clear = 2'h3; @(posedge mclk); #1 event_clear = 2'h0;
    wr(uep_pkg::CMD_EP0_BC, 8'h50); repeat (2) @(posedge mclk);
    #1 chk("in_full", 64, usb_in_count);
    chk("buf_rdata", 8'h05, usb_buf_rdata);
    repeat (8) @(posedge mclk); #1 chk("buf_again", 2'h2, event_status);
    wr(uep_pkg::CMD_EP0_BC, 8'h00); repeat (12) @(posedge mclk);
    #1 chk("zlp_ack", a0 + 1, n_ack);
    chk("zlp_count", 0, usb_in_count);
    event_clear = 2'h3; @(posedge mclk); #1 event_clear = 2'h0;
    // OUT request of three bytes: read count, then bytes, device finishes
    a0 = n_ack; host_setup(64'h0003_0000_0000_5540);
    rd(uep_pkg::CMD_SETUP, v); chk("setup_restart", 8'h40, v);
    repeat (6) @(posedge mclk); #1 chk("out_events", 2'h3, event_status);
    event_clear = 2'h3; @(posedge mclk); #1 event_clear = 2'h0;
    rd(uep_pkg::CMD_EP0_BC, v); chk("out_count", 3, v);
    for (int i = 0; i < 3; i++) begin
      rd(uep_pkg::CMD_EP0_BUF, v); chk("out_byte", 8'hc0 + i, v);
    end
    repeat (2) @(posedge mclk); #1 chk("out_ack", a0 + 1, n_ack);
    chk("out_open", 0, usb_out_open);
    // endpoint feature request goes to the master, acknowledged at once
    a0 = n_ack; host_setup(64'h0000_0086_0000_0102);
    repeat (2) @(posedge mclk); #1 chk("feat_event", 2'h1, event_status);
    chk("feat_ack", a0 + 1, n_ack);
    wr(uep_pkg::CMD_EP0_BC, 8'h00); repeat (2) @(posedge mclk);
    #1 chk("zero_bc_ack", a0 + 2, n_ack);
    event_clear = 2'h3; @(posedge mclk); #1 event_clear = 2'h0;
    $display("test ep0 done");
    // toggle of IN endpoint 6 through the extended port
    wr(uep_pkg::CMD_EXT_LO, 8'h83); wr(uep_pkg::CMD_EXT_HI, 8'he6);
    wr(uep_pkg::CMD_EXT_DATA, 8'h16); wr(uep_pkg::CMD_EXT_DATA, 8'h56);
    repeat (2) @(posedge mclk); #1 chk("tog_set", 1, tog_in[6]);
    rd(uep_pkg::CMD_EXT_DATA, v); chk("tog_q", 1, v[7]);
    wr(uep_pkg::CMD_EXT_DATA, 8'h36); repeat (2) @(posedge mclk);
    #1 chk("tog_clr", 0, tog_in[6]);
    $display("test toggle done");
    wrap_up;
  end
endmodule

//--- testbench/uep_usb_partner.sv
`timescale 1ns/1ps
module uep_usb_partner (
  // clock
  input  wire logic mclk,
  // endpoint zero IN handshake
  input  wire logic usb_in_armed,
  output logic      usb_in_taken,
  // endpoint zero OUT data
  input  wire logic usb_out_open,
  output logic      usb_out_wr,
  output logic [7:0] usb_out_data,
  output logic      usb_out_end
);
  logic [1:0] wait_cnt = 2'h0;
  logic [2:0] ocnt     = 3'h0;
  // host sends three OUT bytes c0, c1, c2 while open, then ends the packet
  always @(posedge mclk) begin
    usb_out_wr   <= usb_out_open && (ocnt < 3'h3);
    usb_out_end  <= usb_out_open && (ocnt == 3'h3);
    usb_out_data <= 8'hc0 + {5'h00, ocnt};
    ocnt         <= !usb_out_open ? 3'h0 : (ocnt == 3'h4) ? ocnt : ocnt + 3'h1;
  end
  // host takes an armed packet after a short delay, one-cycle pulse
  always @(posedge mclk) begin
    usb_in_taken <= usb_in_armed && !usb_in_taken && (wait_cnt == 2'h3);
    wait_cnt     <= usb_in_armed ? wait_cnt + 2'h1 : 2'h0;
  end
endmodule
